// ===== design/rtc_pkg.sv
package rtc_pkg;
	localparam logic [7:0] OFF_SSM       = 8'h48;
	localparam logic [7:0] OFF_BKP_FIRST = 8'h50;
	localparam logic [7:0] OFF_BKP_LAST  = 8'hCC;
	localparam logic [7:0] OFF_STATUS    = 8'hE0;
	localparam logic [7:0] OFF_MASK      = 8'hE4;
	localparam int         NUM_BACKUP    = 32;
	localparam int         BKP_IDX_W     = 5;
	localparam int         MASKCNT_LSB   = 24;
	localparam int         MASKCNT_MSB   = 27;
	localparam int         SSV_MSB       = 14;
	localparam logic [31:0] SSM_RSV_MASK = 32'hF0FF8000;
	localparam logic [3:0]  MASKCNT_NONE = 4'h0;
	localparam logic [3:0]  MASKCNT_FULL = 4'hF;
	localparam logic [3:0]  MASKCNT_RST  = 4'h0;
	localparam logic [14:0] SSV_RST      = 15'h0000;
	localparam logic [31:0] BKP_RST      = 32'h00000000;
	localparam int         NUM_EVT       = 3;
	localparam int         EVT_ALARM     = 0;
	localparam int         EVT_TAMPER    = 1;
	localparam int         EVT_REJECT    = 2;
	localparam logic [2:0] EVT_RST       = 3'h0;
	localparam int         NUM_TAMPER    = 3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// ===== design/rtc_alarm_b_subsecond_and_backup.sv
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_b_subsecond_and_backup
	import rtc_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic [15:0]           subsec_counter,
	input  wire logic                  subsec_tick,
	input  wire logic                  seconds_increment,
	input  wire logic                  alarm_b_fields_match,
	input  wire logic                  alarm_b_irq_enable,
	input  wire logic                  init_mode,
	input  wire logic                  write_unlocked,
	input  wire logic [NUM_TAMPER-1:0] tamper_detect_flag,
	output logic                       alarm_b_match,
	output logic                       irq
);

	function automatic logic is_backup(input logic [7:0] a);
		return (a >= OFF_BKP_FIRST) && (a <= OFF_BKP_LAST) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [BKP_IDX_W-1:0] backup_index(input logic [7:0] a);
		logic [7:0] d;
		d = a - OFF_BKP_FIRST;
		return d[BKP_IDX_W+1:2];
	endfunction

	logic                  accept;
	logic                  wr_pend;
	logic                  rd_pend;
	logic [7:0]            bus_addr;
	logic [3:0]            mask_count;
	logic [14:0]           ss_value;
	logic [15:0]           cmp_wide;
	logic [14:0]           cmp_mask;
	logic                  ss_match;
	logic                  fire_cond;
	logic                  ss_we;
	logic                  ss_allowed;
	logic                  tamper_any;
	logic                  tamper_q;
	logic [NUM_EVT-1:0]    status;
	logic [NUM_EVT-1:0]    irq_mask;
	logic [NUM_EVT-1:0]    events;
	logic [NUM_EVT-1:0]    next_status;
	logic [31:0]           rd_value;
	logic [31:0]           backup_word [NUM_BACKUP];

	assign accept     = hsel & htrans[1] & hready;
	assign tamper_any = |tamper_detect_flag;
	assign ss_we      = wr_pend & (bus_addr == OFF_SSM);
	assign ss_allowed = write_unlocked & (~alarm_b_irq_enable | init_mode);

	// bus phases: writes zero wait, reads one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			bus_addr  <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= accept & hwrite & (hsize == HSIZE_WORD);
			rd_pend   <= accept & ~hwrite;
			hreadyout <= ~(accept & ~hwrite);
			hresp     <= 1'b0;
			if (accept) begin
				bus_addr <= haddr[7:0];
			end
		end
	end

	// sub-second match register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_count <= MASKCNT_RST;
			ss_value   <= SSV_RST;
		end else if (ss_we && ss_allowed) begin
			mask_count <= hwdata[MASKCNT_MSB:MASKCNT_LSB];
			ss_value   <= hwdata[SSV_MSB:0];
		end
	end

	// low n bits compared; 15 gives all ones
	assign cmp_wide = (16'h0001 << mask_count) - 16'h0001;
	assign cmp_mask = cmp_wide[14:0];
	assign ss_match = ((subsec_counter[14:0] ^ ss_value) & cmp_mask) == 15'h0000;

	always_comb begin
		if (mask_count == MASKCNT_NONE) begin
			fire_cond = alarm_b_fields_match & seconds_increment;
		end else begin
			fire_cond = alarm_b_fields_match & subsec_tick & ss_match;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm_b_match <= 1'b0;
		end else begin
			alarm_b_match <= fire_cond;
		end
	end

	// backup words, cleared only by power-on reset or tamper
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BACKUP; gi++) begin : g_bkp
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					backup_word[gi] <= BKP_RST;
				end else if (tamper_any) begin
					backup_word[gi] <= BKP_RST;
				end else if (wr_pend && is_backup(bus_addr)
					&& backup_index(bus_addr) == BKP_IDX_W'(gi)) begin
					backup_word[gi] <= hwdata;
				end
			end
		end
	endgenerate

	// event capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tamper_q <= 1'b0;
		end else begin
			tamper_q <= tamper_any;
		end
	end

	always_comb begin
		events             = EVT_RST;
		events[EVT_ALARM]  = fire_cond;
		events[EVT_TAMPER] = tamper_any & ~tamper_q;
		events[EVT_REJECT] = ss_we & ~ss_allowed;
		next_status        = status;
		if (rd_pend && bus_addr == OFF_STATUS) begin
			next_status = EVT_RST;
		end
		// a new event wins over the read clear
		next_status = next_status | events;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= EVT_RST;
			irq    <= 1'b0;
		end else begin
			status <= next_status;
			irq    <= |(next_status & irq_mask);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask <= EVT_RST;
		end else if (wr_pend && bus_addr == OFF_MASK) begin
			irq_mask <= hwdata[NUM_EVT-1:0];
		end
	end

	// read mux
	always_comb begin
		rd_value = 32'h00000000;
		if (bus_addr == OFF_SSM) begin
			rd_value = {4'h0, mask_count, 9'h000, ss_value};
		end else if (bus_addr == OFF_STATUS) begin
			rd_value[NUM_EVT-1:0] = status;
		end else if (bus_addr == OFF_MASK) begin
			rd_value[NUM_EVT-1:0] = irq_mask;
		end else if (is_backup(bus_addr)) begin
			rd_value = backup_word[backup_index(bus_addr)];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend) begin
			hrdata <= rd_value;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_ss_try;
		ss_we;
	endsequence

	sequence s_ss_blocked;
		s_ss_try ##0 !ss_allowed;
	endsequence

	sequence s_tamper_on;
		$rose(tamper_any);
	endsequence

	property p_mask0_fire;
		mask_count == 4'h0 && alarm_b_fields_match && seconds_increment |=> alarm_b_match;
	endproperty
	a_mask0_fire: assert property (p_mask0_fire) else $error("mask zero alarm missed");

	property p_mask0_quiet;
		mask_count == 4'h0 && !seconds_increment |=> !alarm_b_match;
	endproperty
	a_mask0_quiet: assert property (p_mask0_quiet) else $error("mask zero fired early");

	property p_mask3;
		mask_count == 4'h3 && alarm_b_fields_match && subsec_tick
			&& subsec_counter[2:0] == ss_value[2:0] |=> alarm_b_match;
	endproperty
	a_mask3: assert property (p_mask3) else $error("partial compare failed");

	property p_full_miss;
		mask_count == 4'hF && subsec_counter[14:0] != ss_value |=> !alarm_b_match;
	endproperty
	a_full_miss: assert property (p_full_miss) else $error("full compare fired on mismatch");

	property p_overflow;
		mask_count == 4'hF && alarm_b_fields_match && subsec_tick
			&& subsec_counter[14:0] == ss_value |=> alarm_b_match;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow bit affected compare");

	property p_ss_blocked;
		s_ss_blocked |=> $stable(ss_value) && $stable(mask_count) && status[EVT_REJECT];
	endproperty
	a_ss_blocked: assert property (p_ss_blocked) else $error("locked write took effect");

	property p_ss_unlock;
		s_ss_try ##0 !write_unlocked |=> $stable(ss_value);
	endproperty
	a_ss_unlock: assert property (p_ss_unlock) else $error("write without unlock took effect");

	property p_ss_write;
		s_ss_try ##0 ss_allowed |=> ss_value == $past(hwdata[14:0]);
	endproperty
	a_ss_write: assert property (p_ss_write) else $error("allowed write lost");

	property p_bkp_write;
		wr_pend && is_backup(bus_addr) && !tamper_any
			|=> backup_word[backup_index($past(bus_addr))] == $past(hwdata);
	endproperty
	a_bkp_write: assert property (p_bkp_write) else $error("backup write lost");

	property p_bkp_hold;
		!wr_pend && !tamper_any |=> $stable(backup_word[0]);
	endproperty
	a_bkp_hold: assert property (p_bkp_hold) else $error("backup word changed unasked");

	property p_tamper;
		s_tamper_on |=> backup_word[0] == 32'h00000000 && backup_word[NUM_BACKUP-1] == 32'h00000000;
	endproperty
	a_tamper: assert property (p_tamper) else $error("tamper did not clear backup");

	property p_ssm_rsv;
		rd_pend && bus_addr == OFF_SSM |=> (hrdata & SSM_RSV_MASK) == 32'h00000000;
	endproperty
	a_ssm_rsv: assert property (p_ssm_rsv) else $error("reserved bits read nonzero");

	sequence s_rd_take;
		accept && !hwrite;
	endsequence

	sequence s_bkp_try;
		wr_pend && is_backup(bus_addr);
	endsequence

	property p_rd_wait;
		s_rd_take |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

	property p_bkp_read;
		rd_pend && is_backup(bus_addr) && !tamper_any
			|=> hrdata == backup_word[backup_index($past(bus_addr))];
	endproperty
	a_bkp_read: assert property (p_bkp_read) else $error("backup read wrong");

	property p_bkp_tamper_write;
		s_bkp_try ##0 tamper_any |=> backup_word[backup_index($past(bus_addr))] == BKP_RST;
	endproperty
	a_bkp_tamper_write: assert property (p_bkp_tamper_write) else $error("write beat tamper");

	property p_tamper_hold;
		tamper_any |=> backup_word[0] == BKP_RST && backup_word[NUM_BACKUP-1] == BKP_RST;
	endproperty
	a_tamper_hold: assert property (p_tamper_hold) else $error("backup not held clear");

	property p_tamper_flag;
		s_tamper_on |=> status[EVT_TAMPER];
	endproperty
	a_tamper_flag: assert property (p_tamper_flag) else $error("tamper event not flagged");

	property p_ss_mask_write;
		s_ss_try ##0 ss_allowed |=> mask_count == $past(hwdata[MASKCNT_MSB:MASKCNT_LSB]);
	endproperty
	a_ss_mask_write: assert property (p_ss_mask_write) else $error("mask count write lost");

	property p_ss_idle;
		!ss_we |=> $stable(ss_value) && $stable(mask_count);
	endproperty
	a_ss_idle: assert property (p_ss_idle) else $error("sub-second changed unasked");

	property p_unlock_flag;
		s_ss_try ##0 !write_unlocked |=> status[EVT_REJECT];
	endproperty
	a_unlock_flag: assert property (p_unlock_flag) else $error("locked write not flagged");

	property p_mask1_miss;
		mask_count == 4'h1 && subsec_counter[0] != ss_value[0] |=> !alarm_b_match;
	endproperty
	a_mask1_miss: assert property (p_mask1_miss) else $error("one bit compare fired");

	property p_mask14_hit;
		mask_count == 4'hE && alarm_b_fields_match && subsec_tick
			&& subsec_counter[13:0] == ss_value[13:0] |=> alarm_b_match;
	endproperty
	a_mask14_hit: assert property (p_mask14_hit) else $error("fourteen bit compare missed");

	property p_tick_needed;
		mask_count != MASKCNT_NONE && !subsec_tick |=> !alarm_b_match;
	endproperty
	a_tick_needed: assert property (p_tick_needed) else $error("compare fired without tick");

	property p_fields_needed;
		!alarm_b_fields_match |=> !alarm_b_match;
	endproperty
	a_fields_needed: assert property (p_fields_needed) else $error("alarm without fields");

	property p_bkp_hold_last;
		!wr_pend && !tamper_any |=> $stable(backup_word[NUM_BACKUP-1]);
	endproperty
	a_bkp_hold_last: assert property (p_bkp_hold_last) else $error("last word changed");

endmodule
`default_nettype wire

// ===== tb/tb_rtc_alarm_b_subsecond_and_backup.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_alarm_b_subsecond_and_backup
	import rtc_pkg::*;
;
	typedef struct packed {
		logic [3:0]  mask;
		logic [14:0] val;
		logic [15:0] cnt;
		logic        tick;
		logic        sec;
		logic        fm;
		logic        exp;
	} row_t;

	logic                  hclk;
	logic                  hresetn;
	logic                  hsel;
	logic                  hwrite;
	logic                  hreadyout;
	logic                  hresp;
	logic [1:0]            htrans;
	logic [2:0]            hsize;
	logic [2:0]            sz;
	logic [31:0]           haddr;
	logic [31:0]           hwdata;
	logic [31:0]           hrdata;
	logic [31:0]           rdat;
	logic [15:0]           subsec_counter;
	logic                  subsec_tick;
	logic                  seconds_increment;
	logic                  alarm_b_fields_match;
	logic                  alarm_b_irq_enable;
	logic                  init_mode;
	logic                  write_unlocked;
	logic [NUM_TAMPER-1:0] tamper_detect_flag;
	logic                  alarm_b_match;
	logic                  irq;
	int                    errors;
	int                    num_checks;

	row_t rows [11] = '{
		'{4'h0, 15'h0000, 16'h1234, 1'h0, 1'h1, 1'h1, 1'h1},
		'{4'h0, 15'h1234, 16'h1234, 1'h1, 1'h0, 1'h1, 1'h0},
		'{4'h0, 15'h0000, 16'h0000, 1'h0, 1'h1, 1'h0, 1'h0},
		'{4'h1, 15'h0001, 16'h7FFF, 1'h1, 1'h0, 1'h1, 1'h1},
		'{4'h1, 15'h0001, 16'h0002, 1'h1, 1'h0, 1'h1, 1'h0},
		'{4'h3, 15'h0005, 16'h1235, 1'h1, 1'h0, 1'h1, 1'h1},
		'{4'hE, 15'h2ABC, 16'h6ABC, 1'h1, 1'h0, 1'h1, 1'h1},
		'{4'hE, 15'h2ABC, 16'h2ABD, 1'h1, 1'h0, 1'h1, 1'h0},
		'{4'hF, 15'h4321, 16'hC321, 1'h1, 1'h0, 1'h1, 1'h1},
		'{4'hF, 15'h4321, 16'h0321, 1'h1, 1'h0, 1'h1, 1'h0},
		'{4'hF, 15'h4321, 16'h4321, 1'h0, 1'h1, 1'h1, 1'h0}
	};

	rtc_alarm_b_subsecond_and_backup u_dut (
		.hclk                 (hclk),
		.hresetn              (hresetn),
		.hsel                 (hsel),
		.haddr                (haddr),
		.htrans               (htrans),
		.hwrite               (hwrite),
		.hsize                (hsize),
		.hwdata               (hwdata),
		.hready               (hreadyout),
		.hrdata               (hrdata),
		.hreadyout            (hreadyout),
		.hresp                (hresp),
		.subsec_counter       (subsec_counter),
		.subsec_tick          (subsec_tick),
		.seconds_increment    (seconds_increment),
		.alarm_b_fields_match (alarm_b_fields_match),
		.alarm_b_irq_enable   (alarm_b_irq_enable),
		.init_mode            (init_mode),
		.write_unlocked       (write_unlocked),
		.tamper_detect_flag   (tamper_detect_flag),
		.alarm_b_match        (alarm_b_match),
		.irq                  (irq)
	);

	function automatic logic [31:0] ssm(input logic [3:0] m, input logic [14:0] v);
		return {4'h0, m, 9'h000, v};
	endfunction

	task automatic conclude();
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wait_ready();
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'h1);
	endtask

	// address phase held until hready, then data phase until hready
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rdat = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask

	task automatic rc(input logic [31:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h00000000);
		chk(rdat, exp);
	endtask

	initial begin
		hclk = 1'h0;
		forever #25 hclk = ~hclk;
	end

	initial begin
		repeat (5000) @(posedge hclk);
		errors++;
		conclude();
	end

	initial begin
		hresetn = 1'h0;
		hsel = 1'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = HSIZE_WORD;
		sz = HSIZE_WORD;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		subsec_counter = 16'h0000;
		subsec_tick = 1'h0;
		seconds_increment = 1'h0;
		alarm_b_fields_match = 1'h0;
		alarm_b_irq_enable = 1'h0;
		init_mode = 1'h0;
		write_unlocked = 1'h1;
		tamper_detect_flag = 3'h0;
		errors = 0;
		num_checks = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		chk({31'h0, hreadyout}, 32'h00000001);
		chk({31'h0, hresp}, 32'h00000000);
		chk({31'h0, irq}, 32'h00000000);
		chk({31'h0, alarm_b_match}, 32'h00000000);
		rc(32'(OFF_SSM), 32'h00000000);
		rc(32'(OFF_BKP_FIRST), 32'h00000000);
		rc(32'(OFF_STATUS), 32'h00000000);
		foreach (rows[i]) begin
			wr(32'(OFF_SSM), SSM_RSV_MASK | ssm(rows[i].mask, rows[i].val));
			rc(32'(OFF_SSM), ssm(rows[i].mask, rows[i].val));
			subsec_counter <= rows[i].cnt;
			subsec_tick <= rows[i].tick;
			seconds_increment <= rows[i].sec;
			alarm_b_fields_match <= rows[i].fm;
			@(posedge hclk);
			subsec_tick <= 1'h0;
			seconds_increment <= 1'h0;
			#1;
			chk({31'h0, alarm_b_match}, {31'h0, rows[i].exp});
			@(posedge hclk);
		end
		rc(32'(OFF_STATUS), 32'h00000001);
		rc(32'(OFF_STATUS), 32'h00000000);
		alarm_b_irq_enable <= 1'h1;
		wr(32'(OFF_SSM), ssm(4'h5, 15'h1111));
		rc(32'(OFF_SSM), ssm(4'hF, 15'h4321));
		init_mode <= 1'h1;
		wr(32'(OFF_SSM), ssm(4'h5, 15'h1111));
		rc(32'(OFF_SSM), ssm(4'h5, 15'h1111));
		write_unlocked <= 1'h0;
		wr(32'(OFF_SSM), ssm(4'h6, 15'h2222));
		rc(32'(OFF_SSM), ssm(4'h5, 15'h1111));
		write_unlocked <= 1'h1;
		init_mode <= 1'h0;
		alarm_b_irq_enable <= 1'h0;
		rc(32'(OFF_STATUS), 32'h00000004);
		for (int i = 0; i < NUM_BACKUP; i++)
			wr(32'(OFF_BKP_FIRST + 4 * i), 32'hA5A50000 + 32'(i));
		for (int i = 0; i < NUM_BACKUP; i++)
			rc(32'(OFF_BKP_FIRST + 4 * i), 32'hA5A50000 + 32'(i));
		wr(32'(OFF_BKP_LAST + 4), 32'hFFFFFFFF);
		rc(32'(OFF_BKP_LAST + 4), 32'h00000000);
		sz = 3'h0;
		wr(32'(OFF_BKP_FIRST), 32'h00000000);
		sz = HSIZE_WORD;
		rc(32'(OFF_BKP_FIRST), 32'hA5A50000);
		wr(32'(OFF_MASK), 32'h00000002);
		rc(32'(OFF_MASK), 32'h00000002);
		chk({31'h0, hresp}, 32'h00000000);
		for (int t = 0; t < NUM_TAMPER; t++) begin
			tamper_detect_flag <= 3'(1 << t);
			repeat (2) @(posedge hclk);
			chk({31'h0, irq}, 32'h00000001);
			rc(32'(OFF_BKP_LAST), 32'h00000000);
			wr(32'(OFF_BKP_LAST), 32'h12345678);
			rc(32'(OFF_BKP_LAST), 32'h00000000);
			rc(32'(OFF_STATUS), 32'h00000002);
			chk({31'h0, irq}, 32'h00000000);
			tamper_detect_flag <= 3'h0;
			rc(32'(OFF_BKP_LAST), 32'h00000000);
			wr(32'(OFF_BKP_LAST), 32'h0000005A + 32'(t));
			rc(32'(OFF_BKP_LAST), 32'h0000005A + 32'(t));
		end
		// masked tamper event: status set, no interrupt
		wr(32'(OFF_MASK), 32'h00000000);
		tamper_detect_flag <= 3'h4;
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h00000000);
		rc(32'(OFF_STATUS), 32'h00000002);
		tamper_detect_flag <= 3'h0;
		@(posedge hclk);
		conclude();
	end
endmodule
`default_nettype wire
